// ===== design/cvsf_defines.svh
// Summary of operation
// - bits 15:14 name the flagging channel
// - errors latch until status read or upper-word read of the flagging channel
// - channel codes 2,3 only on four-channel variant
// - bit 13 sets on under-range error
// - bit 12 sets on over-range error
// - bit 11 sets on watchdog timeout
// - bit 10 sets on amplitude above 1.8 V
// - bit 9 sets on amplitude below 1.2 V
// - bit 8 sets on zero count error
// - status read clears the error flags
// - single mode: bit 6 on each result
// - sequential mode: bit 6 after all active channels
// - bits 3..0 flag unread results, ch0 high
// - channel 2,3 pending bits four-channel only
// - under-range reported only with its enable set
// - result-ready reported only with its enable set
`ifndef CVSF_DEFINES_SVH
`define CVSF_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CVSF_ADDR_W 8
`define CVSF_DATA_W 16
`define CVSF_STATUS_ADDR 8'h18
`define CVSF_NCH 4

// ----------------------------------------
// status fields
// ----------------------------------------
`define CVSF_CHAN_HI 15
`define CVSF_CHAN_LO 14
`define CVSF_FLAG_HI 13
`define CVSF_FLAG_LO 8
`define CVSF_RSV7 7
`define CVSF_RESULT_READY_FLAG_BIT 6
`define CVSF_RSV_HI 5
`define CVSF_RSV_LO 4
`define CVSF_PEND_HI 3
`define CVSF_PEND_LO 0
`define CVSF_NFLAG 6
`define CVSF_K_UR 5
`define CVSF_K_OR 4
`define CVSF_K_WD 3
`define CVSF_K_AHE 2
`define CVSF_K_ALE 1
`define CVSF_K_ZC 0

// ----------------------------------------
// error configuration fields
// ----------------------------------------
`define CVSF_CFG_UR_INT 7
`define CVSF_CFG_ZC_INT 2
`define CVSF_CFG_RESULT_READY_FLAG_INT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CVSF_RST_DATA 16'h0000
`define CVSF_MASK_ALL 4'hF
`define CVSF_MASK_TWO 4'h3
`define CVSF_ONE_HOT 4'h1

`endif

// ===== design/cvsf_pkg.sv
`include "cvsf_defines.svh"

package cvsf_pkg;

    typedef logic [`CVSF_NCH-1:0] cvsf_chmask_t;

    typedef struct packed {
        logic [1:0] error_source_channel;
        logic [`CVSF_NFLAG-1:0] err_flags;
        logic result_ready_flag;
        cvsf_chmask_t seq_seen;
        logic [`CVSF_DATA_W-1:0] rd_data;
        logic rd_valid;
        logic alert_n;
    } cvsf_state_s;

    typedef struct packed {
        cvsf_chmask_t pending;
        cvsf_chmask_t upper_seen;
    } cvsf_pend_s;

endpackage : cvsf_pkg

// ===== design/cvsf_pend_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvsf_defines.svh"

interface cvsf_pend_if;
    logic [`CVSF_NCH-1:0] conv_set;
    logic [`CVSF_NCH-1:0] upper_rd;
    logic [`CVSF_NCH-1:0] lower_rd;
    logic [`CVSF_NCH-1:0] pending;

    modport tracker (
        input conv_set,
        input upper_rd,
        input lower_rd,
        output pending
    );

    modport owner (
        output conv_set,
        output upper_rd,
        output lower_rd,
        input pending
    );
endinterface : cvsf_pend_if

`default_nettype wire

// ===== design/cvsf_pending.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvsf_defines.svh"

module cvsf_pending (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    cvsf_pend_if.tracker pif
);

    cvsf_pkg::cvsf_pend_s st_ff;
    cvsf_pkg::cvsf_pend_s nxt_st;

    // ----------------------------------------
    // per-channel unread tracking
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        for (int c = 0; c < `CVSF_NCH; c++) begin
            if (pif.upper_rd[c]) begin
                nxt_st.upper_seen[c] = 1'b1;
            end
            // both words must be read; lower word completes the pair
            if (pif.lower_rd[c] && (st_ff.upper_seen[c] || pif.upper_rd[c])) begin
                nxt_st.pending[c] = 1'b0;
                nxt_st.upper_seen[c] = 1'b0;
            end
            // a fresh result wins over a same-cycle read
            if (pif.conv_set[c]) begin
                nxt_st.pending[c] = 1'b1;
                nxt_st.upper_seen[c] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pif.pending = st_ff.pending;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pend_set: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (|pif.conv_set) |=> ((st_ff.pending & $past(pif.conv_set)) == $past(pif.conv_set))
    ) else $error("pending bit not set by new result");

    a_pend_clear: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ((pif.upper_rd[0] && !pif.conv_set[0]) ##1 (pif.lower_rd[0] && !pif.conv_set[0] && !pif.upper_rd[0]))
        |=> !st_ff.pending[0]
    ) else $error("pending bit not cleared after both word reads");

endmodule : cvsf_pending

`default_nettype wire

// ===== design/cvsf_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvsf_defines.svh"

module cvsf_status (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_rd,
    input wire logic [`CVSF_ADDR_W-1:0] i_reg_addr,
    input wire logic [`CVSF_DATA_W-1:0] i_err_cfg,
    input wire logic i_four_ch,
    input wire logic i_err_valid,
    input wire logic [`CVSF_NFLAG-1:0] i_err_kind,
    input wire logic [1:0] i_error_source_channel,
    input wire logic i_conv_done,
    input wire logic [1:0] i_conv_chan,
    input wire logic i_seq_mode,
    input wire logic [`CVSF_NCH-1:0] i_active_mask,
    input wire logic [`CVSF_NCH-1:0] i_upper_rd,
    input wire logic [`CVSF_NCH-1:0] i_lower_rd,
    output logic [`CVSF_DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_alert_n
);

    cvsf_pkg::cvsf_state_s st_ff;
    cvsf_pkg::cvsf_state_s nxt_st;

    logic status_rd;
    logic err_ok;
    logic err_hit;
    logic err_clr;
    logic conv_ok;
    logic ready_evt;
    logic [`CVSF_NFLAG-1:0] kind_en;
    logic [`CVSF_NCH-1:0] conv_hot;
    logic [`CVSF_NCH-1:0] act_mask;
    logic [`CVSF_NCH-1:0] seq_all;
    logic [`CVSF_DATA_W-1:0] status_img;

    cvsf_pend_if pif ();

    // ----------------------------------------
    // unread result tracker
    // ----------------------------------------
    cvsf_pending u_pending (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .pif(pif.tracker)
    );

    // results from missing channels never reach the tracker
    assign pif.conv_set = conv_ok ? conv_hot : '0;
    assign pif.upper_rd = i_upper_rd;
    assign pif.lower_rd = i_lower_rd;

    // ----------------------------------------
    // event qualification
    // ----------------------------------------
    always_comb begin
        status_rd = i_reg_rd && (i_reg_addr == `CVSF_STATUS_ADDR);
        // two-channel part has no channels 2 and 3
        err_ok = i_four_ch || !i_error_source_channel[1];
        // routing enables line up with flag order ur..zc
        kind_en = i_err_kind & i_err_cfg[`CVSF_CFG_UR_INT:`CVSF_CFG_ZC_INT];
        err_hit = i_err_valid && err_ok && (|kind_en);
        err_clr = status_rd || i_upper_rd[st_ff.error_source_channel];
        conv_ok = i_conv_done && (i_four_ch || !i_conv_chan[1]);
        conv_hot = `CVSF_ONE_HOT << i_conv_chan;
        act_mask = i_active_mask & (i_four_ch ? `CVSF_MASK_ALL : `CVSF_MASK_TWO);
        seq_all = st_ff.seq_seen | conv_hot;
        if (!i_seq_mode) begin
            ready_evt = conv_ok;
        end else begin
            // wait for every active channel of the sweep
            ready_evt = conv_ok && ((seq_all & act_mask) == act_mask);
        end
    end

    // ----------------------------------------
    // status image
    // ----------------------------------------
    always_comb begin
        status_img = `CVSF_RST_DATA;
        status_img[`CVSF_CHAN_HI:`CVSF_CHAN_LO] = st_ff.error_source_channel;
        status_img[`CVSF_FLAG_HI:`CVSF_FLAG_LO] = st_ff.err_flags;
        status_img[`CVSF_RESULT_READY_FLAG_BIT] = st_ff.result_ready_flag;
        // channel 0 sits in the highest pending bit
        for (int c = 0; c < `CVSF_NCH; c++) begin
            status_img[`CVSF_PEND_HI - c] = pif.pending[c];
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rd_valid = 1'b0;
        if (i_reg_rd) begin
            // other registers live elsewhere; this slice answers zero
            nxt_st.rd_data = status_rd ? status_img : `CVSF_RST_DATA;
            nxt_st.rd_valid = 1'b1;
        end
        if (err_clr) begin
            nxt_st.err_flags = '0;
        end
        if (status_rd) begin
            nxt_st.result_ready_flag = 1'b0;
        end
        // sets come after clears so a same-cycle event survives
        if (err_hit) begin
            nxt_st.err_flags = nxt_st.err_flags | kind_en;
            nxt_st.error_source_channel = i_error_source_channel;
        end
        if (!i_seq_mode || ready_evt) begin
            nxt_st.seq_seen = '0;
        end else if (conv_ok) begin
            nxt_st.seq_seen = seq_all;
        end
        if (ready_evt && i_err_cfg[`CVSF_CFG_RESULT_READY_FLAG_INT]) begin
            nxt_st.result_ready_flag = 1'b1;
        end
        // alert follows the reported flags, low while any is up
        nxt_st.alert_n = !((|nxt_st.err_flags) || nxt_st.result_ready_flag);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
            st_ff.alert_n <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_rd_data = st_ff.rd_data;
    assign o_rd_valid = st_ff.rd_valid;
    assign o_alert_n = st_ff.alert_n;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_chan_reported: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        status_rd |=> o_rd_data[`CVSF_CHAN_HI:`CVSF_FLAG_LO] == $past({st_ff.error_source_channel, st_ff.err_flags})
    ) else $error("status read returned wrong channel or flags");

    a_flags_held: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ((|st_ff.err_flags) && !err_clr && !err_hit) |=> st_ff.err_flags == $past(st_ff.err_flags)
    ) else $error("error flags changed without a clearing read");

    a_chan_variant: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_err_valid && i_error_source_channel[1] && !i_four_ch) |=> st_ff.error_source_channel == $past(st_ff.error_source_channel)
    ) else $error("missing channel took the error source");

    a_ur_set: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_err_valid && err_ok && i_err_kind[`CVSF_K_UR] && i_err_cfg[`CVSF_CFG_UR_INT])
        |=> st_ff.err_flags[`CVSF_K_UR] && !o_alert_n
    ) else $error("under-range flag or alert missing");

    a_ur_gated: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_err_cfg[`CVSF_CFG_UR_INT] && !st_ff.err_flags[`CVSF_K_UR]) |=> !st_ff.err_flags[`CVSF_K_UR]
    ) else $error("under-range flag set while its enable is off");

    a_zc_set: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_err_valid && err_ok && i_err_kind[`CVSF_K_ZC] && i_err_cfg[`CVSF_CFG_ZC_INT])
        |=> st_ff.err_flags[`CVSF_K_ZC]
    ) else $error("zero count flag missing");

    a_read_clears: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (status_rd && !i_err_valid && !i_conv_done) |=> (st_ff.err_flags == '0) && !st_ff.result_ready_flag && o_alert_n
    ) else $error("status read did not clear flags");

    a_result_ready_flag_single: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_seq_mode && conv_ok && i_err_cfg[`CVSF_CFG_RESULT_READY_FLAG_INT]) |=> st_ff.result_ready_flag && !o_alert_n
    ) else $error("result-ready not set in single mode");

    a_result_ready_flag_seq_wait: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_seq_mode && !ready_evt && !st_ff.result_ready_flag) |=> !st_ff.result_ready_flag
    ) else $error("result-ready set before the sweep completed");

    a_result_ready_flag_gated: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_err_cfg[`CVSF_CFG_RESULT_READY_FLAG_INT] && !st_ff.result_ready_flag) |=> !st_ff.result_ready_flag
    ) else $error("result-ready set while its enable is off");

    a_rsv_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_rst_n)
        status_rd |=> !o_rd_data[`CVSF_RSV7] && (o_rd_data[`CVSF_RSV_HI:`CVSF_RSV_LO] == 2'b00)
    ) else $error("reserved status bits read nonzero");

endmodule : cvsf_status

`default_nettype wire

// ===== testbench/cvsf_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// host side: fetches one channel's result words
// ----------------------------------------
module cvsf_host_model (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_go,
    input wire logic [1:0] i_chan,
    input wire logic i_skip_upper,
    output logic [3:0] o_upper_rd,
    output logic [3:0] o_lower_rd
);
    logic lo_pend;
    logic [1:0] lo_chan;

    // upper word first, lower word one cycle later
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_upper_rd <= 4'h0;
            o_lower_rd <= 4'h0;
            lo_pend <= 1'b0;
            lo_chan <= 2'h0;
        end else begin
            o_upper_rd <= (i_go && !i_skip_upper) ? 4'h1 << i_chan : 4'h0;
            lo_pend <= i_go;
            lo_chan <= i_chan;
            o_lower_rd <= lo_pend ? 4'h1 << lo_chan : 4'h0;
        end
    end
endmodule : cvsf_host_model

`default_nettype wire

// ===== testbench/test_converter_status_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "cvsf_defines.svh"

module test_converter_status_flags;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] cfg = 16'h00FD;
    logic four = 1'b1;
    logic ev = 1'b0;
    logic [5:0] kind = 6'h00;
    logic [1:0] ech = 2'h0;
    logic cd = 1'b0;
    logic [1:0] cch = 2'h0;
    logic seq = 1'b0;
    logic [3:0] mask = 4'hF;
    logic go = 1'b0;
    logic [1:0] hch = 2'h0;
    logic skip = 1'b0;
    wire logic [3:0] up_rd;
    wire logic [3:0] lo_rd;
    logic [15:0] rdata;
    logic rvalid;
    logic alert_n;
    int error_cnt = 0;
    int compares = 0;
    // kind, channel, status image expected
    logic [23:0] rows [6] = '{{6'h20, 2'h1, 16'h6000}, {6'h10, 2'h0, 16'h1000}, {6'h08, 2'h2, 16'h8800},
                              {6'h04, 2'h3, 16'hC400}, {6'h02, 2'h1, 16'h4200}, {6'h01, 2'h0, 16'h0100}};

    always #25 clk = ~clk;

    cvsf_status dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_rd(rd), .i_reg_addr(addr), .i_err_cfg(cfg),
        .i_four_ch(four), .i_err_valid(ev), .i_err_kind(kind), .i_error_source_channel(ech), .i_conv_done(cd),
        .i_conv_chan(cch), .i_seq_mode(seq), .i_active_mask(mask), .i_upper_rd(up_rd), .i_lower_rd(lo_rd),
        .o_rd_data(rdata), .o_rd_valid(rvalid), .o_alert_n(alert_n));

    cvsf_host_model host (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_chan(hch), .i_skip_upper(skip),
        .o_upper_rd(up_rd), .o_lower_rd(lo_rd));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk) rd <= 1'b1;
        addr <= a;
        @(posedge clk) rd <= 1'b0;
        #1;
        check("rd_valid", 16'h0001, {15'h0, rvalid});
        check("status", exp, rdata);
    endtask : rd_chk

    task automatic err(input logic [5:0] k, input logic [1:0] c);
        @(posedge clk) ev <= 1'b1;
        kind <= k;
        ech <= c;
        @(posedge clk) ev <= 1'b0;
        #1;
    endtask : err

    task automatic conv(input logic [1:0] c);
        @(posedge clk) cd <= 1'b1;
        cch <= c;
        @(posedge clk) cd <= 1'b0;
        #1;
    endtask : conv

    task automatic fetch(input logic [1:0] c, input logic s);
        @(posedge clk) go <= 1'b1;
        hch <= c;
        skip <= s;
        @(posedge clk) go <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : fetch

    task automatic alert(input logic exp);
        check("alert_n", {15'h0, exp}, {15'h0, alert_n});
    endtask : alert

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        alert(1'b1);
        rd_chk(8'h18, 16'h0000);
        rd_chk(8'h19, 16'h0000);
        // every error kind, then the read must have cleared it
        foreach (rows[i]) begin
            err(rows[i][23:18], rows[i][17:16]);
            alert(1'b0);
            // host learns the source channel here before trimming its drive
            rd_chk(8'h18, rows[i][15:0]);
            rd_chk(8'h18, rows[i][15:0] & 16'hC000);
        end
        // disabled under-range leaves no trace
        @(posedge clk) cfg <= 16'h007D;
        err(6'h20, 2'h1);
        alert(1'b1);
        rd_chk(8'h18, 16'h0000);
        // two-channel part ignores channels 2 and 3
        @(posedge clk) cfg <= 16'h00FD;
        four <= 1'b0;
        err(6'h20, 2'h2);
        rd_chk(8'h18, 16'h0000);
        err(6'h20, 2'h1);
        rd_chk(8'h18, 16'h6000);
        @(posedge clk) four <= 1'b1;
        // upper word of another channel does not clear, own channel does
        err(6'h01, 2'h3);
        fetch(2'h2, 1'b0);
        alert(1'b0);
        fetch(2'h3, 1'b0);
        alert(1'b1);
        rd_chk(8'h18, 16'hC000);
        // single mode result and pending bookkeeping
        conv(2'h0);
        alert(1'b0);
        rd_chk(8'h18, 16'hC048);
        rd_chk(8'h18, 16'hC008);
        fetch(2'h0, 1'b1);
        rd_chk(8'h18, 16'hC008);
        fetch(2'h0, 1'b0);
        rd_chk(8'h18, 16'hC000);
        // sequential mode over channels 0 and 2
        @(posedge clk) seq <= 1'b1;
        mask <= 4'h5;
        conv(2'h0);
        rd_chk(8'h18, 16'hC008);
        conv(2'h2);
        rd_chk(8'h18, 16'hC04A);
        fetch(2'h0, 1'b0);
        fetch(2'h2, 1'b0);
        rd_chk(8'h18, 16'hC000);
        // result-ready routing disabled
        @(posedge clk) seq <= 1'b0;
        mask <= 4'hF;
        cfg <= 16'h00FC;
        conv(2'h1);
        alert(1'b1);
        rd_chk(8'h18, 16'hC004);
        // two-channel part keeps no pending bit for channel 3
        @(posedge clk) four <= 1'b0;
        conv(2'h3);
        rd_chk(8'h18, 16'hC004);
        @(posedge clk) four <= 1'b1;
        conv(2'h3);
        rd_chk(8'h18, 16'hC005);
        // reset in mid-run clears everything
        err(6'h3F, 2'h2);
        @(posedge clk) rst_n <= 1'b0;
        @(posedge clk) rst_n <= 1'b1;
        #1;
        alert(1'b1);
        rd_chk(8'h18, 16'h0000);
        give_verdict();
    end
endmodule : test_converter_status_flags

`default_nettype wire
